// ---- design/hbg_pkg.sv ----
package hbg_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int CLK_PERIOD_X10  = CLK_PERIOD_NS * 10;
	localparam int NOV_X10_PER_PF  = 55;
	localparam int DESAT_NS_PER_PF = 14;
	localparam int DESAT_PF_OFS    = 7;
	localparam int LATCH_MS        = 14;
	localparam int LATCH_CYC       = LATCH_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SSD_NS          = 500;
	localparam int SSD_CYC         = (SSD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// register map
	localparam logic [11:0] REG_NOV    = 12'h000;
	localparam logic [11:0] REG_BLANK  = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [15:0] NOV_PF_RST   = 16'h0024;
	localparam logic [15:0] BLANK_PF_RST = 16'h0044;

	// status bit positions
	localparam int ST_LOCAL  = 0;
	localparam int ST_PRIM   = 1;
	localparam int ST_LOW_F  = 2;
	localparam int ST_HIGH_F = 3;
	localparam int ST_LOW_G  = 4;
	localparam int ST_HIGH_G = 5;

	// synchronised pin positions
	localparam int PIN_LS  = 0;
	localparam int PIN_HS  = 1;
	localparam int PIN_JMP = 2;
	localparam int PIN_LDS = 3;
	localparam int PIN_HDS = 4;
	localparam int PIN_LUV = 5;
	localparam int PIN_HUV = 6;
	localparam int PIN_PUV = 7;
	localparam int NPINS   = 8;

	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} hbg_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} hbg_apb_rsp_t;

	typedef enum logic [4:0] {
		CH_RUN   = 5'h01,
		CH_SSD   = 5'h02,
		CH_LATCH = 5'h04,
		CH_WAIT  = 5'h08,
		CH_EDGE  = 5'h10
	} hbg_ch_st_t;

	typedef enum logic [2:0] {
		PR_RUN   = 3'h1,
		PR_LATCH = 3'h2,
		PR_WAIT  = 3'h4
	} hbg_pr_st_t;

	typedef struct packed {
		hbg_ch_st_t  st;
		logic        gate;
		logic        ssd;
		logic        fault;
		logic        cmd_q;
		logic [23:0] blank_acc;
		logic [31:0] cnt;
	} hbg_ch_state_t;

	typedef struct packed {
		logic [NPINS-1:0] sync1;
		logic [NPINS-1:0] sync2;
		logic [1:0][23:0] nov_acc;
		hbg_pr_st_t       pst;
		logic [31:0]      pcnt;
		logic [15:0]      nov_pf;
		logic [15:0]      blank_pf;
		logic [31:0]      prdata;
		logic             pled;
	} hbg_top_state_t;

endpackage

// ---- design/hbg_channel.sv ----
`timescale 1ns/1ps
module hbg_channel #(
	parameter int LATCH_CYCLES = hbg_pkg::LATCH_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        cmd,
	input  wire logic        drain_sense,
	input  wire logic        uvlo,
	input  wire logic        prim_block,
	input  wire logic [23:0] blank_lim,
	output logic             gate_out,
	output logic             ssd_out,
	output logic             fault_out
);
	import hbg_pkg::*;

	hbg_ch_state_t s_ff;
	hbg_ch_state_t nxt_s;
	logic          cmd_rise;
	logic          desat;

	// gate path, blanking, soft shutdown and fault timer
	always_comb begin
		nxt_s = s_ff;
		nxt_s.cmd_q = cmd;
		cmd_rise = cmd & ~s_ff.cmd_q;
		desat = s_ff.gate && (s_ff.blank_acc >= blank_lim) && drain_sense;
		case (s_ff.st)
			CH_RUN: begin
				nxt_s.gate = cmd;
				nxt_s.ssd = 1'b0;
				nxt_s.fault = 1'b0;
				if (s_ff.gate && cmd) begin
					if (s_ff.blank_acc < blank_lim) begin
						nxt_s.blank_acc = 24'(s_ff.blank_acc + CLK_PERIOD_NS);
					end
				end else begin
					nxt_s.blank_acc = 24'h000000;
				end
				if (uvlo || desat) begin
					// soft turn-off and fault pull-down
					nxt_s.st = CH_SSD;
					nxt_s.gate = 1'b0;
					nxt_s.ssd = 1'b1;
					nxt_s.fault = 1'b1;
					nxt_s.cnt = 32'h00000001;
				end else if (prim_block) begin
					nxt_s.st = CH_EDGE;
					nxt_s.gate = 1'b0;
				end
			end
			CH_SSD: begin
				nxt_s.gate = 1'b0;
				nxt_s.cnt = 32'(s_ff.cnt + 1);
				if (s_ff.cnt >= 32'(SSD_CYC)) begin
					nxt_s.ssd = 1'b0;
					nxt_s.st = CH_LATCH;
				end
			end
			CH_LATCH: begin
				nxt_s.cnt = 32'(s_ff.cnt + 1);
				if (s_ff.cnt >= 32'(LATCH_CYCLES - 1)) begin
					nxt_s.st = CH_WAIT;
				end
			end
			CH_WAIT: begin
				if (!uvlo) begin
					nxt_s.fault = 1'b0;
					nxt_s.st = CH_EDGE;
				end
			end
			CH_EDGE: begin
				nxt_s.gate = 1'b0;
				nxt_s.blank_acc = 24'h000000;
				if (uvlo && !prim_block) begin
					nxt_s.st = CH_SSD;
					nxt_s.ssd = 1'b1;
					nxt_s.fault = 1'b1;
					nxt_s.cnt = 32'h00000001;
				end else if (cmd_rise && !prim_block) begin
					nxt_s.st = CH_RUN;
					nxt_s.gate = 1'b1;
				end
			end
			default: begin
				nxt_s.st = CH_EDGE;
				nxt_s.gate = 1'b0;
				nxt_s.ssd = 1'b0;
			end
		endcase
	end

	// state register, gate held off until first edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '{st: CH_EDGE, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign gate_out  = s_ff.gate;
	assign ssd_out   = s_ff.ssd;
	assign fault_out = s_ff.fault;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_gate_follows: assert property (
		(s_ff.st == CH_RUN && $past(s_ff.st) == CH_RUN && !$past(uvlo)
			&& !$past(desat) && !$past(prim_block))
		|-> gate_out == $past(cmd))
		else $error("gate did not follow command");
	a_ssd_gate_off: assert property (
		ssd_out |-> !gate_out && fault_out)
		else $error("gate on during soft shutdown");
	a_uvlo_trips: assert property (
		(s_ff.st == CH_RUN && uvlo) |=> ssd_out && fault_out && !gate_out)
		else $error("undervoltage did not trip channel");
	a_fault_hold: assert property (
		$fell(fault_out) |-> $past(s_ff.cnt) >= 32'(LATCH_CYCLES - 1))
		else $error("fault released before latch time");
	a_resume_edge: assert property (
		(s_ff.st == CH_EDGE) ##1 (s_ff.st == CH_RUN)
		|-> $past(cmd) && !$past(cmd, 2))
		else $error("resumed without rising command edge");
	a_blank_desat: assert property (
		(s_ff.st == CH_RUN && gate_out && s_ff.blank_acc < blank_lim
			&& !uvlo && !prim_block) |=> !fault_out)
		else $error("desaturation seen inside blanking");

endmodule

// ---- design/hbg_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - two LEDs, power lit from the first clock after reset, fault lit on any fault.
// - local mode derives both gates from the high-side input.
// - jumper absent gives direct mode, jumper present local mode.
// - local non-overlap delay is 5.5 ns per pF of the setting.
// - input edges reach the gate output after a propagation delay.
// - after blanking with no desaturation the fault output stays high.
// - desaturation soft-stops the gate and holds fault until timeout.
// - undervoltage soft-stops the gate and holds fault until timeout.
// - every internal fault stays latched for 14 ms.
// - after the latch the gate waits for a rising command edge.
// - primary fault pulls both fault pins, secondary only its own.
module hbg_top #(
	parameter int LATCH_CYCLES = hbg_pkg::LATCH_CYC
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire hbg_pkg::hbg_apb_req_t apb_req,
	output hbg_pkg::hbg_apb_rsp_t      apb_rsp,
	input  wire logic                  low_side_pwm_in,
	input  wire logic                  high_side_pwm_in,
	input  wire logic                  mode_jumper,
	input  wire logic                  low_drain_sense,
	input  wire logic                  high_drain_sense,
	input  wire logic                  low_uvlo_in,
	input  wire logic                  high_uvlo_in,
	input  wire logic                  prim_uvlo_in,
	output logic                       low_gate_out,
	output logic                       high_gate_out,
	output logic                       low_ssd_out,
	output logic                       high_ssd_out,
	output logic                       low_fault_out_n,
	output logic                       low_fault_oe,
	output logic                       high_fault_out_n,
	output logic                       high_fault_oe,
	output logic                       power_led,
	output logic                       fault_led
);
	import hbg_pkg::*;

	hbg_top_state_t   s_ff;
	hbg_top_state_t   nxt_s;
	logic [NPINS-1:0] pins;
	logic             local_mode;
	logic [1:0]       raw_cmd;
	logic [1:0]       ch_cmd;
	logic [1:0]       ch_gate;
	logic [1:0]       ch_ssd;
	logic [1:0]       ch_fault;
	logic [1:0]       drain;
	logic [1:0]       uvlo;
	logic [23:0]      nov_lim;
	logic [23:0]      blank_lim;
	logic             prim_fault;
	logic             acc_phase;
	logic             wr_en;
	logic             addr_hit;
	logic [31:0]      rd_val;
	logic [31:0]      status;

	// raw pin bundle, index 0 low side, 1 high side
	assign pins = {prim_uvlo_in, high_uvlo_in, low_uvlo_in,
		high_drain_sense, low_drain_sense, mode_jumper,
		high_side_pwm_in, low_side_pwm_in};

	// decoded synchronised inputs
	assign local_mode = s_ff.sync2[PIN_JMP];
	assign drain = {s_ff.sync2[PIN_HDS], s_ff.sync2[PIN_LDS]};
	assign uvlo  = {s_ff.sync2[PIN_HUV], s_ff.sync2[PIN_LUV]};
	assign prim_fault = (s_ff.pst != PR_RUN);

	// delay limits in tenths of ns and in ns
	assign nov_lim   = 24'(s_ff.nov_pf * NOV_X10_PER_PF);
	assign blank_lim = 24'(DESAT_NS_PER_PF
		* (s_ff.blank_pf + DESAT_PF_OFS));

	// command selection per mode
	always_comb begin
		if (local_mode) begin
			raw_cmd[1] = s_ff.sync2[PIN_HS];
			raw_cmd[0] = ~s_ff.sync2[PIN_HS];
		end else begin
			raw_cmd[1] = s_ff.sync2[PIN_HS];
			raw_cmd[0] = s_ff.sync2[PIN_LS];
		end
	end

	// apb decode and read mux
	assign acc_phase = apb_req.psel & apb_req.penable;
	assign addr_hit  = (apb_req.paddr == REG_NOV)
		|| (apb_req.paddr == REG_BLANK)
		|| (apb_req.paddr == REG_STATUS);
	assign wr_en = acc_phase & apb_req.pwrite & addr_hit;

	always_comb begin
		status = 32'h00000000;
		status[ST_LOCAL]  = local_mode;
		status[ST_PRIM]   = prim_fault;
		status[ST_LOW_F]  = ch_fault[0];
		status[ST_HIGH_F] = ch_fault[1];
		status[ST_LOW_G]  = ch_gate[0];
		status[ST_HIGH_G] = ch_gate[1];
		case (apb_req.paddr)
			REG_NOV:    rd_val = {16'h0000, s_ff.nov_pf};
			REG_BLANK:  rd_val = {16'h0000, s_ff.blank_pf};
			REG_STATUS: rd_val = status;
			default:    rd_val = 32'h00000000;
		endcase
	end

	// next state: synchronisers, non-overlap, primary fault, registers
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sync1 = pins;
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.pled = 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (!raw_cmd[i]) begin
				nxt_s.nov_acc[i] = 24'h000000;
			end else if (s_ff.nov_acc[i] < nov_lim
				|| s_ff.nov_acc[i] == 24'h000000) begin
				nxt_s.nov_acc[i] = 24'(s_ff.nov_acc[i] + CLK_PERIOD_X10);
			end
		end
		case (s_ff.pst)
			PR_RUN: begin
				if (s_ff.sync2[PIN_PUV]) begin
					nxt_s.pst = PR_LATCH;
					nxt_s.pcnt = 32'h00000001;
				end
			end
			PR_LATCH: begin
				nxt_s.pcnt = 32'(s_ff.pcnt + 1);
				if (s_ff.pcnt >= 32'(LATCH_CYCLES - 1)) begin
					nxt_s.pst = PR_WAIT;
				end
			end
			PR_WAIT: begin
				if (!s_ff.sync2[PIN_PUV]) begin
					nxt_s.pst = PR_RUN;
				end
			end
			default: nxt_s.pst = PR_LATCH;
		endcase
		if (apb_req.psel && !apb_req.penable) begin
			nxt_s.prdata = rd_val;
		end
		if (wr_en && apb_req.paddr == REG_NOV) begin
			nxt_s.nov_pf = apb_req.pwdata[15:0];
		end
		if (wr_en && apb_req.paddr == REG_BLANK) begin
			nxt_s.blank_pf = apb_req.pwdata[15:0];
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '{pst: PR_RUN, nov_pf: NOV_PF_RST,
				blank_pf: BLANK_PF_RST, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// in local mode, turn-on held back until the non-overlap time has run out
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (local_mode) begin
				ch_cmd[i] = raw_cmd[i] && s_ff.nov_acc[i] != 24'h000000
					&& s_ff.nov_acc[i] >= nov_lim;
			end else begin
				ch_cmd[i] = raw_cmd[i];
			end
		end
	end

	// one gate channel per side
	for (genvar g = 0; g < 2; g++) begin : g_ch
		hbg_channel #(
			.LATCH_CYCLES (LATCH_CYCLES)
		) u_ch (
			.pclk        (pclk),
			.presetn     (presetn),
			.cmd         (ch_cmd[g]),
			.drain_sense (drain[g]),
			.uvlo        (uvlo[g]),
			.prim_block  (prim_fault),
			.blank_lim   (blank_lim),
			.gate_out    (ch_gate[g]),
			.ssd_out     (ch_ssd[g]),
			.fault_out   (ch_fault[g])
		);
	end

	// outputs
	assign low_gate_out  = ch_gate[0];
	assign high_gate_out = ch_gate[1];
	assign low_ssd_out   = ch_ssd[0];
	assign high_ssd_out  = ch_ssd[1];

	// open-drain fault pins, low only while driven
	assign low_fault_out_n  = 1'b0;
	assign high_fault_out_n = 1'b0;
	assign low_fault_oe  = prim_fault | ch_fault[0];
	assign high_fault_oe = prim_fault | ch_fault[1];

	// status leds
	assign power_led = s_ff.pled;
	assign fault_led = prim_fault | (|ch_fault);

	// apb answers at once, error on unmapped address
	assign apb_rsp.prdata  = s_ff.prdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = acc_phase & ~addr_hit;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_no_overlap: assert property (
		local_mode |-> !(ch_cmd[0] && ch_cmd[1]))
		else $error("both local commands on together");
	a_prim_both: assert property (
		prim_fault |-> low_fault_oe && high_fault_oe)
		else $error("primary fault missing on a pin");
	a_sec_own: assert property (
		(!prim_fault && ch_fault[0] && !ch_fault[1])
		|-> low_fault_oe && !high_fault_oe)
		else $error("secondary fault on wrong pin");
	a_led_state: assert property (
		$past(presetn) |-> power_led
			&& (fault_led == (low_fault_oe || high_fault_oe)))
		else $error("led state wrong");
	a_prim_latch: assert property (
		$rose(prim_fault) |-> prim_fault [*8])
		else $error("primary fault dropped early");
	a_nov_delay: assert property (
		(local_mode && $rose(raw_cmd[1])) |-> !ch_cmd[1])
		else $error("turn-on not delayed");

endmodule

// ---- tb/hbg_pwm_ctrl.sv ----
`timescale 1ns/1ps
// behavioural model of the external pwm controller
module hbg_pwm_ctrl #(
	parameter int DEAD = 3
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] req,
	output logic            pwm_low,
	output logic            pwm_high
);
	int cnt;

	// a request for one side while the other is on turns both commands off for DEAD+1 cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_low <= 1'b0;
			pwm_high <= 1'b0;
			cnt <= 0;
		end else if ((req[0] && pwm_high) || (req[1] && pwm_low)) begin
			pwm_low <= 1'b0;
			pwm_high <= 1'b0;
			cnt <= DEAD;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end else begin
			pwm_low <= req[0];
			pwm_high <= req[1];
		end
	end
endmodule

// ---- tb/hbg_tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import hbg_pkg::*;

	localparam int LAT = 40;

	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	hbg_apb_req_t apb_req = '0;
	hbg_apb_rsp_t apb_rsp;
	logic [1:0]   req = 2'b00;
	logic         mode_jumper = 1'b0;
	logic         low_drain_sense = 1'b0;
	logic         high_drain_sense = 1'b0;
	logic         low_uvlo_in = 1'b0;
	logic         high_uvlo_in = 1'b0;
	logic         prim_uvlo_in = 1'b0;
	wire          low_side_pwm_in;
	wire          high_side_pwm_in;
	logic         low_gate_out;
	logic         high_gate_out;
	logic         low_ssd_out;
	logic         high_ssd_out;
	logic         low_fault_oe;
	logic         high_fault_oe;
	logic         low_fault_out_n;
	logic         high_fault_out_n;
	logic         power_led;
	logic         fault_led;
	logic [5:0]   obs;
	logic [31:0]  r;
	logic         e;
	int           fails = 0;
	int           n_tests = 0;
	int           cyc = 0;
	int           t, n, n1, n2;
	int           lt [2];

	// observed outputs, indexed by the measuring task
	assign obs = {high_fault_oe, low_fault_oe, high_ssd_out,
		low_ssd_out, high_gate_out, low_gate_out};

	always #50 pclk = ~pclk;

	hbg_pwm_ctrl u_hbg_pwm_ctrl (
		.pclk,
		.presetn,
		.req,
		.pwm_low  (low_side_pwm_in),
		.pwm_high (high_side_pwm_in)
	);

	hbg_top #(.LATCH_CYCLES(LAT)) u_hbg_top (
		.pclk,
		.presetn,
		.apb_req,
		.apb_rsp,
		.low_side_pwm_in,
		.high_side_pwm_in,
		.mode_jumper,
		.low_drain_sense,
		.high_drain_sense,
		.low_uvlo_in,
		.high_uvlo_in,
		.prim_uvlo_in,
		.low_gate_out,
		.high_gate_out,
		.low_ssd_out,
		.high_ssd_out,
		.low_fault_out_n,
		.low_fault_oe,
		.high_fault_out_n,
		.high_fault_oe,
		.power_led,
		.fault_led
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.paddr <= a;
		apb_req.pwrite <= w;
		apb_req.pwdata <= d;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		r = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	// cycles until obs[i] reaches v, then cycles it stays (up to m)
	task automatic meas(input int i, input logic v, input int m,
		output int t0, output int w);
		t0 = 0;
		w = 0;
		while (obs[i] !== v && t0 < 200) begin
			@(posedge pclk);
			#1 t0++;
		end
		while (obs[i] === v && w < m) begin
			@(posedge pclk);
			#1 w++;
		end
	endtask

	function automatic int nov_cyc(input int pf);
		return (NOV_X10_PER_PF * pf + CLK_PERIOD_X10 - 1) / CLK_PERIOD_X10;
	endfunction

	// continuous checks of the fault led, fault pins and gate overlap, plus the timeout
	always @(posedge pclk) begin
		#1 cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test;
		end
		if (presetn === 1'b1) begin
			check(fault_led, low_fault_oe | high_fault_oe);
			check(low_gate_out & high_gate_out, 1'b0);
			check({low_fault_out_n, high_fault_out_n}, 2'b00);
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_NOV, 32'h0);
		check(r, {16'h0000, NOV_PF_RST});
		apb(1'b0, REG_BLANK, 32'h0);
		check(r, {16'h0000, BLANK_PF_RST});
		apb(1'b1, 12'h00c, 32'hffffffff);
		check(e, 1'b1);
		check(power_led, 1'b1);
		$display("test done: registers");

		@(posedge pclk);
		req <= 2'b01;
		meas(0, 1'b1, 20, t, n);
		check(t, 4);
		check(low_fault_oe, 1'b0);
		@(posedge pclk);
		req <= 2'b00;
		meas(0, 1'b0, 2, t, n);
		check(t, 4);
		$display("test done: direct edges");

		@(posedge pclk);
		low_drain_sense <= 1'b1;
		req <= 2'b01;
		fork
			meas(2, 1'b1, 20, t, n1);
			meas(4, 1'b1, 100, t, n2);
			begin
				repeat (30) @(posedge pclk);
				#1 check(high_fault_oe, 1'b0);
				check(low_gate_out, 1'b0);
				check(fault_led, 1'b1);
			end
		join
		check(n1, SSD_CYC);
		check(n2, LAT);
		@(posedge pclk);
		low_drain_sense <= 1'b0;
		repeat (5) @(posedge pclk);
		#1 check(low_gate_out, 1'b0);
		req <= 2'b00;
		repeat (3) @(posedge pclk);
		req <= 2'b01;
		meas(0, 1'b1, 2, t, n);
		check(t, 4);
		$display("test done: desaturation");

		@(posedge pclk);
		req <= 2'b10;
		meas(1, 1'b1, 3, t, n);
		@(posedge pclk);
		high_uvlo_in <= 1'b1;
		fork
			meas(3, 1'b1, 20, t, n1);
			meas(5, 1'b1, 100, t, n2);
			begin
				repeat (10) @(posedge pclk);
				high_uvlo_in <= 1'b0;
				#1 check(low_fault_oe, 1'b0);
				check(high_gate_out, 1'b0);
			end
		join
		check(n1, SSD_CYC);
		check(n2, LAT);
		$display("test done: undervoltage");

		@(posedge pclk);
		prim_uvlo_in <= 1'b1;
		fork
			meas(4, 1'b1, 100, t, n1);
			meas(5, 1'b1, 100, t, n2);
			begin
				repeat (5) @(posedge pclk);
				prim_uvlo_in <= 1'b0;
			end
		join
		check(n1, LAT);
		check(n2, LAT);
		check(power_led, 1'b1);
		$display("test done: primary fault");

		@(posedge pclk);
		req <= 2'b00;
		mode_jumper <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, REG_NOV, 32'd100 * (k + 1));
			repeat (20) @(posedge pclk);
			req <= 2'b10;
			meas(1, 1'b1, 3, lt[k], n);
			@(posedge pclk);
			req <= 2'b00;
			meas(0, 1'b1, 3, t, n);
			check(t, lt[k]);
		end
		check(lt[1] - lt[0], nov_cyc(200) - nov_cyc(100));
		check(lt[0] > 4, 1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		check(r, (32'h1 << ST_LOW_G) | (32'h1 << ST_LOCAL));
		$display("test done: local mode");
		end_of_test;
	end
endmodule
